// [hdl/rtseq_defines.vh]
// Constants for the reset time-out sequencer.
`ifndef RTSEQ_DEFINES_VH
`define RTSEQ_DEFINES_VH
// ****************************************
// Oscillator modes
// ****************************************
`define RTSEQ_MODE_W 4
`define RTSEQ_MODE_LP 4'h0
`define RTSEQ_MODE_XT 4'h1
`define RTSEQ_MODE_HS 4'h2
`define RTSEQ_MODE_FAST_CRYSTAL_MULTIPLIED_MODE 4'h3
`define RTSEQ_MODE_EC 4'h4
`define RTSEQ_MODE_EXTERNAL_CLOCK_IO_MODE 4'h5
`define RTSEQ_MODE_RC 4'h6
`define RTSEQ_MODE_RESISTOR_CAP_IO_MODE 4'h7
`define RTSEQ_MODE_INTA 4'h8
`define RTSEQ_MODE_INTB 4'h9
// ****************************************
// Timing
// ****************************************
`define RTSEQ_CLK_HZ 25000000
`define RTSEQ_SETTLE_CYCLES 1024
`define RTSEQ_PUD_BITS 11
`define RTSEQ_LOCK_US 2000
`define RTSEQ_SLOW_TICK_NS 32000
// ****************************************
// Restart addresses and the software brown-out configuration code
// ****************************************
`define RTSEQ_PC_W 21
`define RTSEQ_RESET_VEC 21'h000000
`define RTSEQ_HI_VEC 21'h000008
`define RTSEQ_LO_VEC 21'h000018
`define RTSEQ_PC_STEP 21'h000002
`define RTSEQ_BOR_SW 2'h1
// ****************************************
// APB register map
// ****************************************
`define RTSEQ_A_CTRL 12'h000
`define RTSEQ_A_STATUS 12'h004
`define RTSEQ_A_PC 12'h008
`define RTSEQ_A_CFG 12'h00c
// Flag bit positions in the reset control register view.
`define RTSEQ_B_BOR 0
`define RTSEQ_B_POR 1
`define RTSEQ_B_PD 2
`define RTSEQ_B_TO 3
`define RTSEQ_B_RI 4
`define RTSEQ_B_SW_BROWNOUT_ENABLE 6
`define RTSEQ_B_STACK_UNDERFLOW_FLAG 8
`define RTSEQ_B_STACK_OVERFLOW_FLAG 9
`define RTSEQ_B_INRESET 16
`endif

// [hdl/rtseq_sync.v]
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/100ps
module rtseq_sync #(
  parameter INIT = 1'b0
) (
  // Clock and reset
  input wire clock,
  input wire rstn,
  // Data
  input wire din,
  output reg dout
);
  reg s1;
  reg s2;
  reg s3;
  // The first stage feeds only the second, so metastability never reaches logic.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
      dout <= INIT;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        dout <= s3;
      end
    end
  end
endmodule // rtseq_sync

// [hdl/rtseq_top.v]
// Reset time-out sequencer: delay stages, reset-cause flags, restart address.
// Operation
// - Settle counter holds reset 1024 oscillator input cycles after power-up delay.
// - Settle count only in crystal modes, after power-on or power-managed exit.
// - With multiplier, a fixed 2 ms lock wait follows the settle count.
// - Power-up: power-up delay after power-on pulse, then settle counter.
// - RC modes without power-up delay: none; external/internal modes: power-up only.
// - Power-up delay about 65.5 ms; power-managed exit never uses it.
// - Delays run from power-on; held master clear releases execution at once.
// - Most state unknown at power-on, kept by other resets; rest forced.
// - Watchdog wake-up resumes operation, leaving most registers unchanged.
// - Power-on: address 0, enable/RI/TO/PD set, POR/BOR/stack flags cleared.
// - Reset instruction clears RI; brown-out sets RI/TO/PD, clears BOR.
// - Master clear in run mode sets TO, restarts at reset address.
// - Master clear in idle or sleep sets TO, clears PD.
// - Master clear in full power restarts, flags unchanged.
// - Watchdog expiry when running resets to zero, clears TO.
// - Watchdog expiry in idle/sleep wakes at PC+2, clears TO and PD.
// - Interrupt wake clears PD, PC+2, or vector if a global enable set.
// - With fault reset enabled, overflow resets to zero and sets overflow flag.
// - With fault reset enabled, underflow resets to zero and sets underflow flag.
// - With fault reset disabled, underflow sets its flag without reset.
// - Software brown-out enable survives resets only in config 01 when set.
// - Power-up delay is a 12-bit counter on slow oscillator ticks.
// - Power-up delay enabled when its active-low enable bit is clear.
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/100ps
`include "rtseq_defines.vh"
module rtseq_top #(
  parameter PUD_TICK_NS = `RTSEQ_SLOW_TICK_NS,
  parameter SETTLE_CYCLES = `RTSEQ_SETTLE_CYCLES,
  parameter LOCK_CYCLES = (`RTSEQ_LOCK_US / 1000) * (`RTSEQ_CLK_HZ / 1000)
) (
  // Clock and reset
  input wire clock,
  input wire rstn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Pins and oscillator
  input wire power_on_pulse,
  input wire master_clear_pin_n,
  input wire oscillator_input_pin,
  input wire internal_slow_osc,
  // Configuration
  input wire [3:0] osc_mode,
  input wire power_up_delay_disable_n,
  input wire [1:0] brownout_config,
  input wire stack_fault_reset_enable,
  // Events from the core
  input wire ev_reset_instr,
  input wire ev_brownout,
  input wire ev_watchdog,
  input wire ev_irq_wake,
  input wire ev_stack_over,
  input wire ev_stack_under,
  input wire ev_pm_exit,
  input wire [1:0] power_state,
  input wire [20:0] current_pc,
  input wire high_prio_global_irq_enable,
  input wire low_prio_global_irq_enable,
  // Outputs
  output reg device_reset,
  output reg restart_load,
  output reg [20:0] restart_pc
);
  // ****************************************
  // Sequencer states and power states
  // ****************************************
  localparam ST_POR = 3'h0;
  localparam ST_PUD = 3'h1;
  localparam ST_SETTLE = 3'h2;
  localparam ST_LOCK = 3'h3;
  localparam ST_WAIT_MC = 3'h4;
  localparam ST_RUN = 3'h5;
  localparam PS_FULL = 2'h0;
  localparam PS_PMRUN = 2'h1;
  localparam PS_IDLE = 2'h2;
  localparam PS_SLEEP = 2'h3;
  localparam [31:0] SLOW_TICK_CYC = (PUD_TICK_NS * (`RTSEQ_CLK_HZ / 1000000)) / 1000;
  localparam [`RTSEQ_PUD_BITS:0] PUD_TICKS = {1'b1, {`RTSEQ_PUD_BITS{1'b0}}};

  // ****************************************
  // Input synchronisers
  // ****************************************
  wire por_s;
  wire mc_n_s;
  wire osc_s;
  wire slow_s;
  rtseq_sync #(.INIT(1'b1)) u_por (.clock(clock), .rstn(rstn), .din(power_on_pulse), .dout(por_s));
  rtseq_sync #(.INIT(1'b0)) u_mc (.clock(clock), .rstn(rstn), .din(master_clear_pin_n), .dout(mc_n_s));
  rtseq_sync #(.INIT(1'b0)) u_osc (.clock(clock), .rstn(rstn), .din(oscillator_input_pin), .dout(osc_s));
  rtseq_sync #(.INIT(1'b0)) u_slow (.clock(clock), .rstn(rstn), .din(internal_slow_osc), .dout(slow_s));

  reg osc_d;
  reg slow_d;
  wire osc_edge = osc_s & ~osc_d;
  wire slow_edge = slow_s & ~slow_d;

  // ****************************************
  // Registers
  // ****************************************
  reg [2:0] state;
  reg [`RTSEQ_PUD_BITS:0] pud_cnt;
  reg [31:0] stage_cnt;
  reg power_up;
  reg sw_brownout_enable;
  reg flag_ri;
  reg flag_to;
  reg flag_pd;
  reg flag_por;
  reg flag_bor;
  reg flag_ful;
  reg flag_unf;
  reg mc_n_d;
  reg [1:0] cfg_power_state;
  reg cfg_use_reg;

  wire [1:0] pstate = cfg_use_reg ? cfg_power_state : power_state;
  wire crystal = (osc_mode == `RTSEQ_MODE_LP) || (osc_mode == `RTSEQ_MODE_XT) ||
                 (osc_mode == `RTSEQ_MODE_HS) || (osc_mode == `RTSEQ_MODE_FAST_CRYSTAL_MULTIPLIED_MODE);
  wire pll_on = (osc_mode == `RTSEQ_MODE_FAST_CRYSTAL_MULTIPLIED_MODE);
  wire pud_on = ~power_up_delay_disable_n;
  wire sw_bor = (brownout_config == `RTSEQ_BOR_SW);
  wire asleep = (pstate == PS_IDLE) || (pstate == PS_SLEEP);
  wire mc_fall = mc_n_d & ~mc_n_s;
  wire wr = psel & penable & pwrite & ~pready;
  wire [31:0] flags_word = {15'h0000, device_reset, 6'h00, flag_ful, flag_unf, 1'b0,
                            sw_brownout_enable & sw_bor, 1'b0, flag_ri, flag_to, flag_pd, flag_por, flag_bor};

  // After the settle count, choose lock wait or release.
  wire [2:0] after_settle = pll_on ? ST_LOCK : ST_WAIT_MC;
  wire [2:0] after_pud = crystal ? ST_SETTLE : ST_WAIT_MC;

  // ****************************************
  // Sequencer
  // ****************************************
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state <= ST_POR;
      pud_cnt <= 12'h000;
      stage_cnt <= 32'h00000000;
      power_up <= 1'b1;
      device_reset <= 1'b1;
      osc_d <= 1'b0;
      slow_d <= 1'b0;
      mc_n_d <= 1'b0;
    end else begin
      osc_d <= osc_s;
      slow_d <= slow_s;
      mc_n_d <= mc_n_s;
      // Reset stays asserted until the final stage has ended and the pin is high.
      device_reset <= (state != ST_RUN);
      if (por_s) begin
        state <= ST_POR;
        power_up <= 1'b1;
      end else begin
        case (state)
          ST_POR: begin
            pud_cnt <= 12'h000;
            stage_cnt <= 32'h00000000;
            state <= (pud_on && power_up) ? ST_PUD : after_pud;
          end
          ST_PUD: begin
            // Ticks of the slow oscillator, 2048 of them at nominal 32 us each.
            if (slow_edge) begin
              pud_cnt <= pud_cnt + 12'h001;
            end
            if (pud_cnt == PUD_TICKS) begin
              state <= after_pud;
            end
          end
          ST_SETTLE: begin
            if (osc_edge) begin
              stage_cnt <= stage_cnt + 32'h00000001;
            end
            if (stage_cnt == SETTLE_CYCLES) begin
              stage_cnt <= 32'h00000000;
              state <= after_settle;
            end
          end
          ST_LOCK: begin
            stage_cnt <= stage_cnt + 32'h00000001;
            if (stage_cnt == LOCK_CYCLES - 1) begin
              state <= ST_WAIT_MC;
            end
          end
          ST_WAIT_MC: begin
            // Delays already ran from power-on, so a late pin release starts at once.
            if (mc_n_s) begin
              state <= ST_RUN;
              power_up <= 1'b0;
            end
          end
          ST_RUN: begin
            if (!mc_n_s) begin
              state <= ST_WAIT_MC;
            end else if (ev_pm_exit && crystal) begin
              stage_cnt <= 32'h00000000;
              state <= ST_SETTLE;
            end
          end
          default: begin
            state <= ST_POR;
          end
        endcase
      end
    end
  end

  // ****************************************
  // Reset-cause flags and restart address
  // ****************************************
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sw_brownout_enable <= 1'b1;
      flag_ri <= 1'b1;
      flag_to <= 1'b1;
      flag_pd <= 1'b1;
      flag_por <= 1'b0;
      flag_bor <= 1'b0;
      flag_ful <= 1'b0;
      flag_unf <= 1'b0;
      restart_load <= 1'b0;
      restart_pc <= `RTSEQ_RESET_VEC;
      cfg_power_state <= PS_FULL;
      cfg_use_reg <= 1'b0;
    end else begin
      restart_load <= 1'b0;
      // Software writes first, so a same-cycle hardware event wins.
      if (wr && (paddr == `RTSEQ_A_CTRL)) begin
        sw_brownout_enable <= pwdata[`RTSEQ_B_SW_BROWNOUT_ENABLE] & sw_bor;
        flag_ri <= pwdata[`RTSEQ_B_RI];
        flag_to <= pwdata[`RTSEQ_B_TO];
        flag_pd <= pwdata[`RTSEQ_B_PD];
        flag_por <= pwdata[`RTSEQ_B_POR];
        flag_bor <= pwdata[`RTSEQ_B_BOR];
        flag_ful <= pwdata[`RTSEQ_B_STACK_OVERFLOW_FLAG];
        flag_unf <= pwdata[`RTSEQ_B_STACK_UNDERFLOW_FLAG];
      end else if (wr && (paddr == `RTSEQ_A_CFG)) begin
        cfg_power_state <= pwdata[1:0];
        cfg_use_reg <= pwdata[4];
      end
      if (por_s) begin
        sw_brownout_enable <= 1'b1;
        flag_ri <= 1'b1;
        flag_to <= 1'b1;
        flag_pd <= 1'b1;
        flag_por <= 1'b0;
        flag_bor <= 1'b0;
        flag_ful <= 1'b0;
        flag_unf <= 1'b0;
        restart_pc <= `RTSEQ_RESET_VEC;
      end else if (state == ST_RUN) begin
        // Unlisted state keeps its value through these events.
        if (!sw_bor) begin
          sw_brownout_enable <= 1'b0;
        end
        if (ev_brownout) begin
          flag_ri <= 1'b1;
          flag_to <= 1'b1;
          flag_pd <= 1'b1;
          flag_bor <= 1'b0;
          restart_load <= 1'b1;
          restart_pc <= `RTSEQ_RESET_VEC;
        end else if (mc_fall) begin
          restart_load <= 1'b1;
          restart_pc <= `RTSEQ_RESET_VEC;
          if (pstate == PS_PMRUN) begin
            flag_to <= 1'b1;
          end else if (asleep) begin
            flag_to <= 1'b1;
            flag_pd <= 1'b0;
          end
        end else if (ev_watchdog) begin
          flag_to <= 1'b0;
          restart_load <= 1'b1;
          if (asleep) begin
            flag_pd <= 1'b0;
            restart_pc <= current_pc + `RTSEQ_PC_STEP;
          end else begin
            restart_pc <= `RTSEQ_RESET_VEC;
          end
        end else if (ev_stack_over && stack_fault_reset_enable) begin
          flag_ful <= 1'b1;
          restart_load <= 1'b1;
          restart_pc <= `RTSEQ_RESET_VEC;
        end else if (ev_stack_under) begin
          flag_unf <= 1'b1;
          if (stack_fault_reset_enable) begin
            restart_load <= 1'b1;
            restart_pc <= `RTSEQ_RESET_VEC;
          end
        end else if (ev_reset_instr) begin
          flag_ri <= 1'b0;
          restart_load <= 1'b1;
          restart_pc <= `RTSEQ_RESET_VEC;
        end else if (ev_irq_wake && pstate != PS_FULL) begin
          flag_pd <= 1'b0;
          restart_load <= 1'b1;
          if (high_prio_global_irq_enable) begin
            restart_pc <= `RTSEQ_LO_VEC;
          end else if (low_prio_global_irq_enable) begin
            restart_pc <= `RTSEQ_HI_VEC;
          end else begin
            restart_pc <= current_pc + `RTSEQ_PC_STEP;
          end
        end
      end
    end
  end

  // ****************************************
  // APB slave, one wait state
  // ****************************************
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (psel && penable && !pready) begin
        if ((paddr == `RTSEQ_A_CTRL) || (paddr == `RTSEQ_A_STATUS)) begin
          prdata <= flags_word;
        end else if (paddr == `RTSEQ_A_PC) begin
          prdata <= {11'h000, restart_pc};
        end else if (paddr == `RTSEQ_A_CFG) begin
          prdata <= {27'h0000000, cfg_use_reg, 2'h0, cfg_power_state};
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end
endmodule // rtseq_top

// [verif/rtseq_asserts.sv]
// Port-level assertions for the reset time-out sequencer.
`timescale 1ns/100ps
`include "rtseq_defines.vh"
module rtseq_asserts #(
  parameter SETTLE_CYCLES = 1024,
  parameter LOCK_CYCLES = 50000
) (
  // Clock and reset
  input wire clock,
  input wire rstn,
  // APB handshake
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  // Pins and configuration
  input wire power_on_pulse,
  input wire master_clear_pin_n,
  input wire [3:0] osc_mode,
  input wire power_up_delay_disable_n,
  input wire stack_fault_reset_enable,
  // Events
  input wire ev_reset_instr,
  input wire ev_brownout,
  input wire ev_watchdog,
  input wire ev_irq_wake,
  input wire ev_stack_over,
  input wire ev_stack_under,
  input wire ev_pm_exit,
  input wire [1:0] power_state,
  input wire [20:0] current_pc,
  input wire high_prio_global_irq_enable,
  // Outputs
  input wire device_reset,
  input wire restart_load,
  input wire [20:0] restart_pc
);
  // Only a lone event on a running device has a single defined outcome.
  wire solo;
  assign solo = $onehot({ev_reset_instr, ev_brownout, ev_watchdog, ev_irq_wake, ev_stack_over, ev_stack_under,
    ev_pm_exit}) && master_clear_pin_n && !power_on_pulse && !device_reset;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  apb_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("APB access not answered after one wait");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  load_pulse_a: assert property (restart_load |=> !restart_load)
    else $error("restart_load longer than one cycle");
  clear_hold_a: assert property (!master_clear_pin_n [*8] |-> device_reset)
    else $error("reset released while master clear low");
  rc_nodelay_a: assert property ($fell(power_on_pulse) && osc_mode == `RTSEQ_MODE_RC
    && power_up_delay_disable_n && master_clear_pin_n |-> ##[1:12] !device_reset)
    else $error("delay applied in RC mode");
  over_reset_a: assert property (solo && ev_stack_over && stack_fault_reset_enable |=>
    restart_load && restart_pc == 21'h000000) else $error("overflow restart wrong");
  under_keep_a: assert property (solo && ev_stack_under && !stack_fault_reset_enable |=> !device_reset [*4])
    else $error("underflow caused a reset");
  wdt_wake_a: assert property (solo && ev_watchdog && power_state[1] |=> restart_load && !device_reset
    && restart_pc == $past(current_pc) + 21'h000002) else $error("watchdog wake restart wrong");
  wdt_run_a: assert property (solo && ev_watchdog && !power_state[1] |=>
    restart_load && restart_pc == 21'h000000) else $error("watchdog reset restart wrong");
  irq_vec_a: assert property (solo && ev_irq_wake && power_state != 2'h0 && high_prio_global_irq_enable
    |=> restart_pc == 21'h000018) else $error("interrupt vector wrong");
endmodule // rtseq_asserts

bind rtseq_top rtseq_asserts #(.SETTLE_CYCLES(SETTLE_CYCLES), .LOCK_CYCLES(LOCK_CYCLES)) u_asserts (
  .clock, .rstn, .psel, .penable, .pready, .pslverr, .power_on_pulse, .master_clear_pin_n, .osc_mode,
  .power_up_delay_disable_n, .stack_fault_reset_enable, .ev_reset_instr, .ev_brownout, .ev_watchdog,
  .ev_irq_wake, .ev_stack_over, .ev_stack_under, .ev_pm_exit, .power_state, .current_pc,
  .high_prio_global_irq_enable, .device_reset, .restart_load, .restart_pc);

// [verif/reset_timeout_sequencer_tb_top.sv]
// Self-checking testbench for the reset time-out sequencer.
`timescale 1ns/100ps
`include "rtseq_defines.vh"
module reset_timeout_sequencer_tb_top;
  // Short counts keep the run small; slow clocks tick once per DIV cycles.
  localparam SETTLE = 16;
  localparam LOCK = 20;
  localparam DIV = 8;
  reg clock, rstn, psel, penable, pwrite, err, hi_en, lo_en;
  reg [11:0] paddr;
  reg [31:0] pwdata, rd;
  wire [31:0] prdata;
  wire pready, pslverr, device_reset, restart_load;
  wire [20:0] restart_pc;
  reg power_on_pulse, master_clear_pin_n, oscillator_input_pin, internal_slow_osc;
  reg [3:0] osc_mode;
  reg power_up_delay_disable_n, stack_fault_reset_enable;
  reg [1:0] brownout_config, power_state, div;
  reg [6:0] ev;
  reg [20:0] current_pc;
  integer num_errors, samples_checked, i, s, n;
  rtseq_top #(.SETTLE_CYCLES(SETTLE), .LOCK_CYCLES(LOCK)) DUT (
    .clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .power_on_pulse(power_on_pulse),
    .master_clear_pin_n(master_clear_pin_n), .oscillator_input_pin(oscillator_input_pin),
    .internal_slow_osc(internal_slow_osc), .osc_mode(osc_mode), .power_up_delay_disable_n(power_up_delay_disable_n),
    .brownout_config(brownout_config), .stack_fault_reset_enable(stack_fault_reset_enable),
    .ev_reset_instr(ev[0]), .ev_brownout(ev[1]), .ev_watchdog(ev[2]), .ev_irq_wake(ev[3]), .ev_stack_over(ev[4]),
    .ev_stack_under(ev[5]), .ev_pm_exit(ev[6]), .power_state(power_state), .current_pc(current_pc),
    .high_prio_global_irq_enable(hi_en), .low_prio_global_irq_enable(lo_en), .device_reset(device_reset),
    .restart_load(restart_load), .restart_pc(restart_pc));
  initial begin
    clock = 1'h0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    if (!rstn) begin
      div <= 2'h0;
      oscillator_input_pin <= 1'h0;
      internal_slow_osc <= 1'h0;
    end else begin
      div <= div + 2'h1;
      if (div == 2'h3) begin
        oscillator_input_pin <= ~oscillator_input_pin;
        internal_slow_osc <= ~internal_slow_osc;
      end
    end
  end
  // ****************************************
  // Shared tasks and expectations
  // ****************************************
  task check(input [31:0] seen, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task apb(input wr, input [11:0] a, input [31:0] d);
    begin
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'h1;
      @(posedge clock);
      // Only the watchdog ends a wait for the answer.
      while (pready !== 1'h1) begin
        @(posedge clock);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge clock);
    end
  endtask
  function integer exp_cycles(input [3:0] m, input pud);
    begin
      exp_cycles = pud ? 2048 * DIV : 0;
      if (m <= `RTSEQ_MODE_FAST_CRYSTAL_MULTIPLIED_MODE) exp_cycles = exp_cycles + SETTLE * DIV;
      if (m == `RTSEQ_MODE_FAST_CRYSTAL_MULTIPLIED_MODE) exp_cycles = exp_cycles + LOCK;
    end
  endfunction
  function [31:0] exp_flags(input [31:0] w, input integer e, input [1:0] st);
    begin
      exp_flags = w;
      case (e)
        0: exp_flags[4] = 1'h0;
        1: exp_flags[4:0] = {3'h7, exp_flags[1], 1'h0};
        2: begin
          exp_flags[3] = 1'h0;
          if (st[1]) exp_flags[2] = 1'h0;
        end
        3: exp_flags[2] = 1'h0;
        4: exp_flags[9] = 1'h1;
        5: exp_flags[8] = 1'h1;
        default: begin
          if (st != 2'h0) exp_flags[3] = 1'h1;
          if (st[1]) exp_flags[2] = 1'h0;
        end
      endcase
    end
  endfunction
  // Counts reset cycles after a power-on pulse or a power-managed exit.
  task measure(input [3:0] m, input pud, input pm, input hold);
    integer e;
    begin
      e = exp_cycles(m, pud & ~pm);
      osc_mode <= m;
      power_up_delay_disable_n <= ~pud;
      master_clear_pin_n <= ~hold;
      @(posedge clock);
      if (pm) ev[6] <= 1'h1;
      else power_on_pulse <= 1'h1;
      @(posedge clock);
      ev <= 7'h00;
      repeat (4) @(posedge clock);
      power_on_pulse <= 1'h0;
      n = 0;
      repeat (e + 64) begin
        @(posedge clock);
        n = n + device_reset;
      end
      check(hold ? n == e + 64 : n >= e - 8 && n <= e + 24, 1);
      master_clear_pin_n <= 1'h1;
      repeat (10) @(posedge clock);
      check(device_reset, 0);
    end
  endtask
  task event_run(input integer e, input [1:0] st);
    reg [31:0] w, x;
    begin
      x = $urandom;
      w = (x & 32'h0000035f) | (e == 1 ? 32'h00000040 : 32'h00000000);
      apb(1'h1, `RTSEQ_A_CTRL, w);
      current_pc <= x[30:10];
      hi_en <= x[8];
      lo_en <= x[5];
      stack_fault_reset_enable <= x[7] | (e == 4);
      power_state <= st;
      @(posedge clock);
      if (e == 6) master_clear_pin_n <= 1'h0;
      else ev[e] <= 1'h1;
      @(posedge clock);
      ev <= 7'h00;
      @(posedge clock);
      // The restart strobe stands for the one cycle after the event.
      if (e != 6) check(restart_load, e != 5 || x[7]);
      repeat (9) @(posedge clock);
      master_clear_pin_n <= 1'h1;
      while (device_reset !== 1'h0) begin
        @(posedge clock);
      end
      apb(1'h0, `RTSEQ_A_CTRL, 0);
      check(rd, exp_flags(w, e, st));
      if (e == 3) check(restart_pc, x[8] ? 21'h000018 : x[5] ? 21'h000008 : x[30:10] + 21'h000002);
      else if (e == 2 && st[1]) check(restart_pc, x[30:10] + 21'h000002);
      else if (e != 5 || x[7]) check(restart_pc, 0);
    end
  endtask
  task report_and_stop;
    begin
      if (num_errors == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata, power_on_pulse} = 0;
    {ev, power_state, current_pc, hi_en, lo_en, stack_fault_reset_enable} = 0;
    master_clear_pin_n = 1'h1;
    osc_mode = `RTSEQ_MODE_EC;
    power_up_delay_disable_n = 1'h1;
    brownout_config = 2'h1;
    num_errors = 0;
    samples_checked = 0;
    rd = $urandom(26);
    repeat (2) @(posedge clock);
    rstn <= 1'h1;
    @(posedge clock);
    for (i = 0; i < 10; i = i + 1) begin
      measure(i[3:0], 1'h0, 1'h0, 1'h0);
      measure(i[3:0], 1'h0, 1'h1, 1'h0);
    end
    measure(`RTSEQ_MODE_HS, 1'h0, 1'h0, 1'h1);
    measure(`RTSEQ_MODE_FAST_CRYSTAL_MULTIPLIED_MODE, 1'h1, 1'h0, 1'h0);
    apb(1'h0, `RTSEQ_A_CTRL, 0);
    check(rd, 32'h0000005c);
    check(restart_pc, 0);
    apb(1'h0, `RTSEQ_A_PC, 0);
    check(rd, 32'h00000000);
    apb(1'h0, 12'h010, 0);
    check(err, 1'h1);
    check(rd, 32'h00000000);
    // Override register: only the state field and the enable bit read back.
    apb(1'h1, `RTSEQ_A_CFG, 32'hfffffff3);
    apb(1'h0, `RTSEQ_A_CFG, 0);
    check(rd, 32'h00000013);
    apb(1'h1, `RTSEQ_A_CFG, 0);
    osc_mode <= `RTSEQ_MODE_EC;
    for (i = 0; i < 7; i = i + 1)
      for (s = 0; s < 4; s = s + 1)
        if (i != 3 || s != 0) event_run(i, s[1:0]);
    brownout_config <= 2'h2;
    @(posedge clock);
    apb(1'h0, `RTSEQ_A_CTRL, 0);
    check(rd[6], 0);
    report_and_stop;
  end
  initial begin
    #(40 * 60000);
    num_errors = num_errors + 1;
    report_and_stop;
  end
endmodule // reset_timeout_sequencer_tb_top
